/* File: rtl/cnt_exec.sv */
`timescale 1ns/100ps
// What this block does
// - clear opcode writes zero into the addressed data register.
// - access bit zero picks access bank, one picks bank select register bank.
// - access bit zero, extended set, operand up to 95: indexed from pointer.
// - clear takes four cycles: decode, read, process, write back.
// - watchdog clear zeroes the counter and its postscaler.
// - watchdog clear sets timeout and power-down status bits to one.
// - negate stores inverse plus one, updates negative, overflow, carry, digit carry, zero.
// - table read low bits: keep, post-increment, post-decrement, pre-increment pointer.
module cnt_exec
#(
	parameter int unsigned PROG_AW = 14
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp
);
	import cnt_pkg::*;

	logic [7:0] dataMem [0:4095];
	logic [15:0] progMem [0:(2**PROG_AW)-1];

	logic extEn_q, extEn_d;
	logic [3:0] bank_q, bank_d;
	logic [11:0] fsr2_q, fsr2_d;
	logic [15:0] instr_q, instr_d;
	cnt_flags_t flags_q, flags_d;
	logic timeOut_q, timeOut_d, pwrDown_q, pwrDown_d;
	logic [20:0] table_pointer_q, table_pointer_d;
	logic [7:0] tblLatch_q, tblLatch_d;
	logic [7:0] wdogCount_q, wdogCount_d;
	logic [15:0] wdogPost_q, wdogPost_d;
	logic [11:0] dAddr_q, dAddr_d;
	logic [PROG_AW-1:0] pAddr_q, pAddr_d;
	cnt_phase_t phase_q, phase_d;
	cnt_op_t op_q, op_d;
	logic second_q, second_d;
	logic [7:0] operand_q, operand_d;
	logic [7:0] result_q, result_d;
	logic [11:0] target_q, target_d;
	logic [7:0] busAddr_q, busAddr_d;
	logic busWr_q, busWr_d;
	logic [31:0] hrdata_q, hrdata_d;
	logic hreadyout_q, hresp_q;

	logic wrEn, dmemHw, dmemSw, pmemSw;
	logic [7:0] aluRes;
	cnt_flags_t aluFlags;
	logic [7:0] f;
	cnt_op_t decOp;
	logic [11:0] decTarget;
	logic [15:0] progWord;
	logic [7:0] statusVal;

	cnt_alu u_alu
	(
		.op(op_q),
		.operand(operand_q),
		.flagsIn(flags_q),
		.result(aluRes),
		.flagsOut(aluFlags)
	);

	assign wrEn = busWr_q;
	assign f = instr_q[7:0];
	assign progWord = progMem[table_pointer_q[PROG_AW:1]];
	assign statusVal = {phase_q != PH_IDLE, timeOut_q, pwrDown_q, flags_q};

	// opcode decode and operand address
	always_comb
	begin
		decOp = OP_NOOP;
		if (instr_q[15:9] == OPC_CLEAR)
			decOp = OP_CLEAR;
		else if (instr_q[15:9] == OPC_NEGATE)
			decOp = OP_NEGATE;
		else if (instr_q == OPC_WDCLEAR)
			decOp = OP_WDCLEAR;
		else if (instr_q[15:2] == OPC_TBLREAD)
			decOp = OP_TBLREAD;
		if (!instr_q[8] && extEn_q && f <= INDEX_LIMIT)
			decTarget = 12'(fsr2_q + {4'h0, f});
		else if (!instr_q[8])
			decTarget = (f < ACCESS_SPLIT) ? {4'h0, f} : {SFR_BANK, f};
		else
			decTarget = {bank_q, f};
	end

	// bus front end: address phase captured, read data registered for data phase
	always_comb
	begin
		busWr_d = hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
		busAddr_d = haddr[7:0];
		hrdata_d = 32'h00000000;
		if (hsel && hready && htrans == HTRANS_NONSEQ && !hwrite)
		begin
			unique case (haddr[7:0])
				OFF_CTRL: hrdata_d = {31'h00000000, extEn_q};
				OFF_BANK: hrdata_d = {28'h0000000, bank_q};
				OFF_FSR2: hrdata_d = {20'h00000, fsr2_q};
				OFF_INSTR: hrdata_d = {16'h0000, instr_q};
				OFF_STATUS: hrdata_d = {24'h000000, statusVal};
				OFF_TPTR: hrdata_d = {11'h000, table_pointer_q};
				OFF_TBLLAT: hrdata_d = {24'h000000, tblLatch_q};
				OFF_WDOG: hrdata_d = {8'h00, wdogPost_q, wdogCount_q};
				OFF_DADDR: hrdata_d = {20'h00000, dAddr_q};
				OFF_DDATA: hrdata_d = {24'h000000, dataMem[dAddr_q]};
				OFF_PADDR: hrdata_d = 32'(pAddr_q);
				OFF_PDATA: hrdata_d = {16'h0000, progMem[pAddr_q]};
				default: hrdata_d = 32'h00000000;
			endcase
		end
	end

	// register writes first, then the execution sequencer (hardware wins)
	always_comb
	begin
		extEn_d = extEn_q;
		bank_d = bank_q;
		fsr2_d = fsr2_q;
		instr_d = instr_q;
		flags_d = flags_q;
		timeOut_d = timeOut_q;
		pwrDown_d = pwrDown_q;
		table_pointer_d = table_pointer_q;
		tblLatch_d = tblLatch_q;
		dAddr_d = dAddr_q;
		pAddr_d = pAddr_q;
		phase_d = phase_q;
		op_d = op_q;
		second_d = second_q;
		operand_d = operand_q;
		result_d = result_q;
		target_d = target_q;
		dmemHw = 1'b0;
		dmemSw = 1'b0;
		pmemSw = 1'b0;
		{wdogPost_d, wdogCount_d} = 24'({wdogPost_q, wdogCount_q} + 24'h000001);
		if (wrEn)
		begin
			unique case (busAddr_q)
				OFF_CTRL: extEn_d = hwdata[0];
				OFF_BANK: bank_d = hwdata[3:0];
				OFF_FSR2: fsr2_d = hwdata[11:0];
				OFF_INSTR:
				begin
					if (phase_q == PH_IDLE)
					begin
						instr_d = hwdata[15:0];
						phase_d = PH_DECODE;
						second_d = 1'b0;
					end
				end
				OFF_STATUS:
				begin
					flags_d = hwdata[4:0];
					pwrDown_d = hwdata[ST_PDOWN];
					timeOut_d = hwdata[ST_TOUT];
				end
				OFF_TPTR: table_pointer_d = hwdata[20:0];
				OFF_TBLLAT: tblLatch_d = hwdata[7:0];
				OFF_DADDR: dAddr_d = hwdata[11:0];
				OFF_DDATA: dmemSw = 1'b1;
				OFF_PADDR: pAddr_d = hwdata[PROG_AW-1:0];
				OFF_PDATA: pmemSw = 1'b1;
				default: ;
			endcase
		end
		unique case (phase_q)
			PH_IDLE: ;
			PH_DECODE:
			begin
				if (!second_q)
				begin
					op_d = decOp;
					target_d = decTarget;
				end
				phase_d = PH_READ;
			end
			PH_READ:
			begin
				if (op_q == OP_CLEAR || op_q == OP_NEGATE)
					operand_d = dataMem[target_q];
				phase_d = PH_PROCESS;
			end
			PH_PROCESS:
			begin
				result_d = aluRes;
				if (op_q == OP_TBLREAD && !second_q && instr_q[1:0] == TBL_PREINC)
					table_pointer_d = 21'(table_pointer_q + 21'h000001);
				if (op_q == OP_TBLREAD && second_q)
					operand_d = table_pointer_q[0] ? progWord[15:8] : progWord[7:0];
				phase_d = PH_WRITE;
			end
			PH_WRITE:
			begin
				phase_d = PH_IDLE;
				unique case (op_q)
					OP_CLEAR, OP_NEGATE:
					begin
						dmemHw = 1'b1;
						flags_d = aluFlags;
					end
					OP_WDCLEAR:
					begin
						wdogCount_d = 8'h00;
						wdogPost_d = 16'h0000;
						timeOut_d = 1'b1;
						pwrDown_d = 1'b1;
					end
					OP_TBLREAD:
					begin
						if (!second_q)
						begin
							second_d = 1'b1;
							phase_d = PH_DECODE;
						end
						else
						begin
							tblLatch_d = operand_q;
							if (instr_q[1:0] == TBL_POSTINC)
								table_pointer_d = 21'(table_pointer_q + 21'h000001);
							else if (instr_q[1:0] == TBL_POSTDEC)
								table_pointer_d = 21'(table_pointer_q - 21'h000001);
						end
					end
					default: ;
				endcase
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (dmemHw)
			dataMem[target_q] <= result_q;
		else if (dmemSw)
			dataMem[dAddr_q] <= hwdata[7:0];
		if (pmemSw)
			progMem[pAddr_q] <= hwdata[15:0];
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			extEn_q <= 1'b0;
			bank_q <= 4'h0;
			fsr2_q <= 12'h000;
			instr_q <= OPC_NOOP;
			flags_q <= RST_FLAGS;
			timeOut_q <= RST_TOUT;
			pwrDown_q <= RST_PDOWN;
			table_pointer_q <= 21'h000000;
			tblLatch_q <= 8'h00;
			wdogCount_q <= 8'h00;
			wdogPost_q <= 16'h0000;
			dAddr_q <= 12'h000;
			pAddr_q <= '0;
			phase_q <= PH_IDLE;
			op_q <= OP_NOOP;
			second_q <= 1'b0;
			operand_q <= 8'h00;
			result_q <= 8'h00;
			target_q <= 12'h000;
			busAddr_q <= 8'h00;
			busWr_q <= 1'b0;
			hrdata_q <= 32'h00000000;
			hreadyout_q <= 1'b1;
			hresp_q <= HRESP_OKAY;
		end
		else
		begin
			extEn_q <= extEn_d;
			bank_q <= bank_d;
			fsr2_q <= fsr2_d;
			instr_q <= instr_d;
			flags_q <= flags_d;
			timeOut_q <= timeOut_d;
			pwrDown_q <= pwrDown_d;
			table_pointer_q <= table_pointer_d;
			tblLatch_q <= tblLatch_d;
			wdogCount_q <= wdogCount_d;
			wdogPost_q <= wdogPost_d;
			dAddr_q <= dAddr_d;
			pAddr_q <= pAddr_d;
			phase_q <= phase_d;
			op_q <= op_d;
			second_q <= second_d;
			operand_q <= operand_d;
			result_q <= result_d;
			target_q <= target_d;
			busAddr_q <= busAddr_d;
			busWr_q <= busWr_d;
			hrdata_q <= hrdata_d;
			hreadyout_q <= 1'b1;
			hresp_q <= HRESP_OKAY;
		end
	end

	assign hreadyout = hreadyout_q;
	assign hrdata = hrdata_q;
	assign hresp = hresp_q;
endmodule : cnt_exec

/* File: shared/cnt_pkg.sv */
package cnt_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_BANK = 8'h04;
	localparam logic [7:0] OFF_FSR2 = 8'h08;
	localparam logic [7:0] OFF_INSTR = 8'h0C;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [7:0] OFF_TPTR = 8'h14;
	localparam logic [7:0] OFF_TBLLAT = 8'h18;
	localparam logic [7:0] OFF_WDOG = 8'h1C;
	localparam logic [7:0] OFF_DADDR = 8'h20;
	localparam logic [7:0] OFF_DDATA = 8'h24;
	localparam logic [7:0] OFF_PADDR = 8'h28;
	localparam logic [7:0] OFF_PDATA = 8'h2C;
	// status field positions
	localparam int unsigned ST_C = 0;
	localparam int unsigned ST_DCARRY = 1;
	localparam int unsigned ST_Z = 2;
	localparam int unsigned ST_OVF = 3;
	localparam int unsigned ST_N = 4;
	localparam int unsigned ST_PDOWN = 5;
	localparam int unsigned ST_TOUT = 6;
	localparam int unsigned ST_BUSY = 7;
	// reset values
	localparam logic [4:0] RST_FLAGS = 5'h00;
	localparam logic RST_TOUT = 1'b1;
	localparam logic RST_PDOWN = 1'b1;
	// opcode fields
	localparam logic [6:0] OPC_CLEAR = 7'h35;
	localparam logic [6:0] OPC_NEGATE = 7'h36;
	localparam logic [15:0] OPC_WDCLEAR = 16'h0004;
	localparam logic [15:0] OPC_NOOP = 16'h0000;
	localparam logic [3:0] OPC_NOOP2 = 4'hF;
	localparam logic [13:0] OPC_TBLREAD = 14'h0002;
	// table pointer modes
	localparam logic [1:0] TBL_KEEP = 2'h0;
	localparam logic [1:0] TBL_POSTINC = 2'h1;
	localparam logic [1:0] TBL_POSTDEC = 2'h2;
	localparam logic [1:0] TBL_PREINC = 2'h3;
	// addressing
	localparam logic [7:0] INDEX_LIMIT = 8'h5F;
	localparam logic [7:0] ACCESS_SPLIT = 8'h80;
	localparam logic [3:0] SFR_BANK = 4'hF;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;

	typedef enum {OP_NOOP, OP_CLEAR, OP_NEGATE, OP_WDCLEAR, OP_TBLREAD} cnt_op_t;
	typedef enum {PH_IDLE, PH_DECODE, PH_READ, PH_PROCESS, PH_WRITE} cnt_phase_t;
	typedef struct packed
	{
		logic n;
		logic ovf;
		logic z;
		logic dcy;
		logic c;
	} cnt_flags_t;
endpackage : cnt_pkg

/* File: rtl/cnt_alu.sv */
`timescale 1ns/100ps
module cnt_alu
(
	input cnt_pkg::cnt_op_t op,
	input wire logic [7:0] operand,
	input cnt_pkg::cnt_flags_t flagsIn,
	output logic [7:0] result,
	output cnt_pkg::cnt_flags_t flagsOut
);
	import cnt_pkg::*;

	always_comb
	begin
		result = operand;
		flagsOut = flagsIn;
		unique case (op)
			OP_CLEAR:
			begin
				result = 8'h00;
				flagsOut.z = 1'b1;
			end
			OP_NEGATE:
			begin
				result = 8'(~operand + 8'h01);
				flagsOut.n = result[7];
				flagsOut.z = (result == 8'h00);
				flagsOut.c = (operand == 8'h00);
				flagsOut.dcy = (operand[3:0] == 4'h0);
				flagsOut.ovf = (operand == 8'h80);
			end
			default:
			begin
				result = operand;
			end
		endcase
	end
endmodule : cnt_alu

/* File: verification/cnt_exec_chk.sv */
`timescale 1ns/100ps
module cnt_exec_chk
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic hresp
);
	import cnt_pkg::*;
	logic rdPh_q;
	logic [7:0] rdOff_q;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// marks the data phase of a read
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rdPh_q <= 1'b0;
		else
			rdPh_q <= hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
	end
	always_ff @(posedge clk)
		rdOff_q <= haddr[7:0];
	a_ready_high: assert property (hreadyout)
		else $error("wait state inserted");
	a_resp_okay: assert property (hresp == HRESP_OKAY)
		else $error("response not okay");
	a_idle_zero: assert property (!rdPh_q |-> hrdata == 32'h0)
		else $error("read data outside read");
	a_status_top: assert property (rdPh_q && rdOff_q == OFF_STATUS |-> hrdata[31:8] == 24'h0)
		else $error("status upper bits set");
	a_ctrl_bit: assert property (rdPh_q && rdOff_q == OFF_CTRL |-> hrdata[31:1] == 31'h0)
		else $error("control upper bits set");
	a_latch_byte: assert property (rdPh_q && rdOff_q == OFF_TBLLAT |-> hrdata[31:8] == 24'h0)
		else $error("latch wider than a byte");
	a_ptr_width: assert property (rdPh_q && rdOff_q == OFF_TPTR |-> hrdata[31:21] == 11'h0)
		else $error("pointer wider than 21 bits");
	a_wdog_top: assert property (rdPh_q && rdOff_q == OFF_WDOG |-> hrdata[31:24] == 8'h0)
		else $error("watchdog upper bits set");
	a_data_byte: assert property (rdPh_q && rdOff_q == OFF_DDATA |-> hrdata[31:8] == 24'h0)
		else $error("data byte upper bits set");
endmodule : cnt_exec_chk
bind cnt_exec cnt_exec_chk u_chk (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));

/* File: verification/testbench.sv */
`timescale 1ns/100ps
module testbench;
	import cnt_pkg::*;
	logic clk, rst_n, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rv;
	logic [1:0] htrans;
	logic [2:0] hsize;
	int errCount, checked;
	cnt_exec #(.PROG_AW(14)) dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			errCount++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// one single transfer; read data lands in rv
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		@(posedge clk);
		while (hreadyout !== 1'b1)
			@(posedge clk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (hreadyout !== 1'b1)
			@(posedge clk);
		rv = hrdata;
	endtask : bus
	// issue an opcode, count status reads that still show busy
	task automatic exec(input logic [15:0] op, output int n);
		n = 0;
		bus(1'b1, OFF_INSTR, {16'h0, op});
		bus(1'b0, OFF_STATUS, 32'h0);
		while (rv[ST_BUSY] !== 1'b0 && n < 20)
		begin
			n++;
			bus(1'b0, OFF_STATUS, 32'h0);
		end
	endtask : exec
	task automatic dmem(input logic [11:0] a, input logic [7:0] d);
		bus(1'b1, OFF_DADDR, {20'h0, a});
		bus(1'b1, OFF_DDATA, {24'h0, d});
	endtask : dmem
	task automatic t_clear;
		logic [11:0] ad[5] = '{12'h2A5, 12'hF85, 12'h120, 12'h15F, 12'h060};
		logic [15:0] op[5] = '{16'h6BA5, 16'h6A85, 16'h6A20, 16'h6A5F, 16'h6A60};
		int n;
		bus(1'b1, OFF_BANK, 32'h2);
		bus(1'b1, OFF_FSR2, 32'h100);
		dmem(12'h020, 8'h66);
		for (int i = 0; i < 5; i++)
		begin
			bus(1'b1, OFF_CTRL, {31'h0, i >= 2});
			dmem(ad[i], 8'h5A);
			exec(op[i], n);
			chk("clear cycles", 2, n);
			chk("zero flag", 1, rv[ST_Z]);
			bus(1'b0, OFF_DDATA, 32'h0);
			chk("cleared byte", 32'h0, rv);
		end
		dmem(12'h020, 8'h66);
		bus(1'b0, OFF_DDATA, 32'h0);
		bus(1'b1, OFF_DADDR, 32'h020);
		bus(1'b0, OFF_DDATA, 32'h0);
		chk("direct byte kept", 32'h66, rv);
		bus(1'b1, OFF_CTRL, 32'h0);
		$display("clear test done");
	endtask : t_clear
	task automatic t_negate;
		logic [7:0] v[5] = '{8'h3A, 8'h00, 8'h80, 8'h01, 8'h10};
		logic [7:0] r;
		int n;
		for (int i = 0; i < 5; i++)
		begin
			dmem(12'h2A5, v[i]);
			exec(16'h6DA5, n);
			r = ~v[i] + 8'h01;
			chk("negate flags", {27'h0, r[7], v[i] == 8'h80, r == 8'h0, v[i][3:0] == 4'h0,
				v[i] == 8'h0}, {27'h0, rv[4:0]});
			bus(1'b0, OFF_DDATA, 32'h0);
			chk("negated byte", {24'h0, r}, rv);
		end
		$display("negate test done");
	endtask : t_negate
	task automatic t_wdclear;
		int n;
		bus(1'b1, OFF_STATUS, 32'h0);
		repeat (300) @(posedge clk);
		exec(OPC_WDCLEAR, n);
		chk("status bits", 32'h3, {30'h0, rv[ST_TOUT], rv[ST_PDOWN]});
		bus(1'b0, OFF_WDOG, 32'h0);
		chk("watchdog cleared", 1, rv[23:0] < 24'h20);
		$display("watchdog test done");
	endtask : t_wdclear
	task automatic t_table;
		logic [20:0] p[4] = '{21'h356, 21'h356, 21'h357, 21'h357};
		logic [20:0] q[4] = '{21'h356, 21'h357, 21'h356, 21'h358};
		logic [7:0] l[4] = '{8'h34, 8'h34, 8'h12, 8'hCD};
		int n;
		bus(1'b1, OFF_PADDR, 32'h1AB);
		bus(1'b1, OFF_PDATA, 32'h1234);
		bus(1'b1, OFF_PADDR, 32'h1AC);
		bus(1'b1, OFF_PDATA, 32'hABCD);
		for (int i = 0; i < 4; i++)
		begin
			bus(1'b1, OFF_TPTR, {11'h0, p[i]});
			exec({OPC_TBLREAD, i[1:0]}, n);
			bus(1'b0, OFF_TBLLAT, 32'h0);
			chk("table latch", {24'h0, l[i]}, rv);
			bus(1'b0, OFF_TPTR, 32'h0);
			chk("table pointer", {11'h0, q[i]}, rv);
		end
		$display("table test done");
	endtask : t_table
	task automatic t_nop;
		logic [31:0] s, t;
		int n;
		bus(1'b0, 8'h30, 32'h0);
		chk("unmapped read", 32'h0, rv);
		bus(1'b0, OFF_TBLLAT, 32'h0);
		t = rv;
		for (int i = 0; i < 2; i++)
		begin
			exec(i == 0 ? OPC_NOOP : 16'hF123, n);
			if (i == 0)
				s = rv;
			chk("nop cycles", 2, n);
			chk("nop status", s, rv);
			bus(1'b0, OFF_TBLLAT, 32'h0);
			chk("nop latch", t, rv);
		end
		$display("no-operation test done");
	endtask : t_nop
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checked, errCount);
		if (errCount == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run
	initial
	begin
		rst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		errCount = 0;
		checked = 0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		bus(1'b0, OFF_STATUS, 32'h0);
		chk("status after reset", 32'h60, rv);
		t_clear;
		t_negate;
		t_wdclear;
		t_table;
		t_nop;
		complete_run;
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		errCount++;
		complete_run;
	end
endmodule : testbench
